// file: common/csh_pkg.sv
// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
// Overview of operation
// [RULE1] host sends reference temperature as single float between -30 and 80 C
// [RULE2] reference command stores value as external junction reference, no reply
// [RULE3] open-circuit check takes one bit: zero off, one on
// [RULE4] checking on: each thermocouple reading gets a confirming second reading
// [RULE5] open circuit on confirming reading replaces result with error code
// [RULE6] gauge factor stored per strain channel, channels one to ten only
// [RULE7] strain channel lacking initialization or factor returns not-initialized error
// [RULE8] offset command loads offset and initial voltage floats per channel
// [RULE9] initialization measures offset and initial voltage, stores and sends both
// [RULE10] init reply on stream one, eight bytes: offset first, initial second
// [RULE11] sample-rate command covers channels 1..20; universal variant only 19, 20
// [RULE12] rate code: 0 default, 1 20Hz, 2 1kHz, 3 10kHz, 4 100kHz
// [RULE13] power-up defaults per mode: status 20Hz, count 1Hz, capture 1kHz, timing 100kHz
// [RULE14] at 20Hz and 1kHz a level change needs four agreeing samples
// [RULE15] at debounced rates captured timestamp lags edge by four sample periods
// [RULE16] at 10kHz and 100kHz a single differing sample changes the level
package csh_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int N_STRAIN = 10;
  localparam int N_DIG = 20;
  localparam int UNIV_FIRST_CH = 19;
  localparam int DEBOUNCE_N = 4;
  localparam int DEBOUNCE_LAG = 4;
  // rate frequencies in Hz and derived tick periods in cycles
  localparam int HZ_1 = 1;
  localparam int HZ_20 = 20;
  localparam int HZ_1K = 1_000;
  localparam int HZ_10K = 10_000;
  localparam int HZ_100K = 100_000;
  localparam int DIV_1 = CLK_HZ / HZ_1;
  localparam int DIV_20 = CLK_HZ / HZ_20;
  localparam int DIV_1K = CLK_HZ / HZ_1K;
  localparam int DIV_10K = CLK_HZ / HZ_10K;
  localparam int DIV_100K = CLK_HZ / HZ_100K;
  localparam logic [31:0] REF_TEMP_RESET = 32'h0000_0000;
  localparam logic [15:0] ERR_OPEN_CIRCUIT = 16'hFF80;
  localparam logic [15:0] ERR_NOT_INIT = 16'hFF81;
  localparam int REPLY_BYTES = 8;
  localparam logic [1:0] REPLY_STREAM = 2'h1;

  typedef enum logic [2:0] {
    CSH_RATE_DEF, CSH_RATE_20, CSH_RATE_1K, CSH_RATE_10K, CSH_RATE_100K, CSH_RATE_1
  } csh_rate_t;
  typedef enum logic [2:0] {
    CSH_MODE_STATUS, CSH_MODE_COUNT, CSH_MODE_CAPTURE,
    CSH_MODE_FREQ, CSH_MODE_PERIOD, CSH_MODE_ONESHOT
  } csh_mode_t;
  typedef enum logic [2:0] {
    CSH_CMD_REF_TEMP, CSH_CMD_OC_CHECK, CSH_CMD_GAUGE, CSH_CMD_OFFSET,
    CSH_CMD_INIT, CSH_CMD_RATE
  } csh_op_t;
  typedef struct packed {
    csh_op_t op;
    logic [4:0] chan;
    logic [31:0] arg0;
    logic [31:0] arg1;
  } csh_cmd_t;
  typedef struct packed {
    logic [31:0] offset_v;
    logic [31:0] initial_v;
  } csh_strain_t;
endpackage

// file: rtl/csh_strain_mem.sv
`timescale 1ns/1ps
// per-channel strain parameters; read data registered
module csh_strain_mem (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_fact,
  input wire logic wr_zero,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wr_factor,
  input wire csh_pkg::csh_strain_t wr_zero_data,
  // read port
  input wire logic [3:0] rd_idx,
  output csh_pkg::csh_strain_t rd_zero,
  output logic [31:0] rd_factor
);
  import csh_pkg::*;
  csh_strain_t zero_mem [N_STRAIN];
  logic [31:0] fact_mem [N_STRAIN];

  always_ff @(posedge clk) begin
    if (wr_zero) zero_mem[wr_idx] <= wr_zero_data;
    if (wr_fact) fact_mem[wr_idx] <= wr_factor;
    rd_zero <= zero_mem[rd_idx];
    rd_factor <= fact_mem[rd_idx];
  end
endmodule

// file: rtl/csh_debounce.sv
`timescale 1ns/1ps
// one digital channel: sample on tick, optional four-sample agreement
module csh_debounce (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sampling
  input wire logic tick,
  input wire logic filter_on,
  input wire logic din_sync,
  // result
  output logic level,
  output logic change
);
  import csh_pkg::*;
  logic [2:0] agree;
  wire differ = tick && (din_sync != level);
  // filter wants the current sample to be the fourth agreeing one
  wire accept = differ && (!filter_on || agree == 3'(DEBOUNCE_N - 1)); // RULE14 RULE16

  always_ff @(posedge clk) begin
    if (reset) begin
      level <= 1'b0;
      agree <= 3'h0;
      change <= 1'b0;
    end else begin
      change <= accept;
      if (accept) begin
        level <= din_sync;
        agree <= 3'h0;
      end else if (differ) begin
        agree <= agree + 3'h1;
      end else if (tick) begin
        agree <= 3'h0;
      end
    end
  end

  a_filter_agree: assert property (@(posedge clk) disable iff (reset) // RULE14
    filter_on && accept |-> agree == 3'h3) else $error("level accepted early");
  a_fast_single: assert property (@(posedge clk) disable iff (reset) // RULE16
    !filter_on && differ |=> change) else $error("fast change missed");
endmodule

// file: rtl/csh_cmd_handler.sv
`timescale 1ns/1ps
module csh_cmd_handler (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire logic universal_variant,
  input wire csh_pkg::csh_mode_t [19:0] chan_mode,
  // command port
  input wire logic cmd_valid,
  input wire csh_pkg::csh_cmd_t cmd,
  output logic cmd_ready,
  output logic cmd_reject,
  // thermocouple measurement
  output logic [31:0] ref_temp,
  output logic ref_external,
  output logic oc_check_on,
  input wire logic tc_done,
  input wire logic [15:0] tc_value,
  input wire logic tc_open,
  output logic tc_confirm_req,
  output logic tc_result_valid,
  output logic [15:0] tc_result,
  // strain measurement
  input wire logic strain_req,
  input wire logic [3:0] strain_idx,
  output logic strain_go,
  output logic strain_err,
  output logic [15:0] strain_err_code,
  output logic [31:0] strain_factor,
  output csh_pkg::csh_strain_t strain_zero,
  output logic gauge_meas_req,
  input wire logic gauge_meas_done,
  input wire csh_pkg::csh_strain_t gauge_meas,
  // init reply stream
  output logic reply_valid,
  output logic [1:0] reply_stream,
  output logic [7:0] reply_byte,
  input wire logic reply_ready,
  // digital channels
  input wire logic [19:0] dig_in,
  output logic [19:0] dig_level,
  output logic [19:0] dig_change,
  output logic [19:0] dig_stamp_late
);
  import csh_pkg::*;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CSH_IDLE, CSH_MEAS, CSH_SEND} csh_st_t;
  csh_st_t state;
  csh_cmd_t cmd_r;
  wire take = cmd_valid && cmd_ready;
  wire strain_ok = cmd.chan >= 5'h1 && cmd.chan <= 5'(N_STRAIN); // RULE6
  wire rate_ok = cmd.chan >= 5'h1 && cmd.chan <= 5'(N_DIG)
    && (!universal_variant || cmd.chan >= 5'(UNIV_FIRST_CH)); // RULE11
  wire rate_code_ok = cmd.arg0[31:3] == '0 && cmd.arg0[2:0] <= 3'h4; // RULE12
  wire is_strain_op = cmd.op inside {CSH_CMD_GAUGE, CSH_CMD_OFFSET, CSH_CMD_INIT};
  wire bad = (is_strain_op && !strain_ok)
    || (cmd.op == CSH_CMD_RATE && !(rate_ok && rate_code_ok))
    || (cmd.op == CSH_CMD_OC_CHECK && cmd.arg0[31:1] != '0); // RULE3
  wire good = take && !bad;
  wire [3:0] sidx = cmd.chan[3:0] - 4'h1;
  wire [4:0] didx = cmd.chan - 5'h1;
  assign cmd_ready = state == CSH_IDLE;

  always_ff @(posedge clk) begin
    if (reset) cmd_reject <= 1'b0;
    else cmd_reject <= take && bad;
  end

  a_univ_refuse: assert property (@(posedge clk) disable iff (reset) // RULE11
    take && cmd.op == CSH_CMD_RATE && universal_variant && cmd.chan < 5'(UNIV_FIRST_CH)
    |=> cmd_reject) else $error("rate accepted on fixed channel");

  // ----------------------------------------------------------------
  // reference junction and open-circuit check
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_temp <= REF_TEMP_RESET;
      ref_external <= 1'b0;
      oc_check_on <= 1'b0;
    end else if (good && cmd.op == CSH_CMD_REF_TEMP) begin
      ref_temp <= cmd.arg0; // RULE2
      ref_external <= 1'b1;
    end else if (good && cmd.op == CSH_CMD_OC_CHECK) begin
      oc_check_on <= cmd.arg0[0]; // RULE3
    end
  end

  // range of the value is the host's duty; stored as given
  a_ref_store: assert property (@(posedge clk) disable iff (reset) // RULE2
    good && cmd.op == CSH_CMD_REF_TEMP |=> ref_temp == $past(cmd.arg0) && ref_external)
    else $error("reference not stored");

  // first reading holds back until the confirming one returns
  logic tc_confirming;
  logic [15:0] tc_first;
  always_ff @(posedge clk) begin
    if (reset) begin
      tc_confirming <= 1'b0;
      tc_first <= 16'h0000;
      tc_confirm_req <= 1'b0;
      tc_result_valid <= 1'b0;
      tc_result <= 16'h0000;
    end else begin
      tc_confirm_req <= 1'b0;
      tc_result_valid <= 1'b0;
      if (tc_done && oc_check_on && !tc_confirming) begin
        tc_confirming <= 1'b1; // RULE4
        tc_first <= tc_value;
        tc_confirm_req <= 1'b1;
      end else if (tc_done) begin
        tc_confirming <= 1'b0;
        tc_result_valid <= 1'b1;
        tc_result <= !tc_confirming ? tc_value :
          (tc_open ? ERR_OPEN_CIRCUIT : tc_first); // RULE5
      end
    end
  end

  a_tc_confirm: assert property (@(posedge clk) disable iff (reset) // RULE4
    tc_done && oc_check_on && !tc_confirming |=> !tc_result_valid && tc_confirm_req)
    else $error("result released before confirmation");
  a_tc_open_err: assert property (@(posedge clk) disable iff (reset) // RULE5
    tc_done && tc_confirming && tc_open |=> tc_result == ERR_OPEN_CIRCUIT)
    else $error("open circuit not reported");

  // ----------------------------------------------------------------
  // strain gauge parameters
  // ----------------------------------------------------------------
  logic [N_STRAIN-1:0] have_zero;
  logic [N_STRAIN-1:0] have_factor;
  wire wr_fact = good && cmd.op == CSH_CMD_GAUGE; // RULE6
  wire wr_load = good && cmd.op == CSH_CMD_OFFSET; // RULE8
  wire wr_init = state == CSH_MEAS && gauge_meas_done; // RULE9
  csh_strain_t load_data;
  assign load_data = '{offset_v: cmd.arg0, initial_v: cmd.arg1};
  wire [3:0] wr_idx = wr_init ? cmd_r.chan[3:0] - 4'h1 : sidx;
  wire csh_strain_t wr_zero_data = wr_init ? gauge_meas : load_data;

  csh_strain_mem u_mem (
    .clk(clk),
    .wr_fact(wr_fact),
    .wr_zero(wr_load || wr_init),
    .wr_idx(wr_idx),
    .wr_factor(cmd.arg0),
    .wr_zero_data(wr_zero_data),
    .rd_idx(strain_idx),
    .rd_zero(strain_zero),
    .rd_factor(strain_factor)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      have_zero <= '0;
      have_factor <= '0;
    end else begin
      if (wr_load || wr_init) have_zero[wr_idx] <= 1'b1;
      if (wr_fact) have_factor[sidx] <= 1'b1;
    end
  end

  // answer lines up with the registered memory read
  wire ready_ch = strain_idx < 4'(N_STRAIN) && have_zero[strain_idx] && have_factor[strain_idx];
  always_ff @(posedge clk) begin
    if (reset) begin
      strain_go <= 1'b0;
      strain_err <= 1'b0;
      strain_err_code <= 16'h0000;
    end else begin
      strain_go <= strain_req && ready_ch; // RULE7
      strain_err <= strain_req && !ready_ch;
      strain_err_code <= (strain_req && !ready_ch) ? ERR_NOT_INIT : 16'h0000;
    end
  end

  a_strain_refuse: assert property (@(posedge clk) disable iff (reset) // RULE7
    strain_req && !(have_zero[strain_idx] && have_factor[strain_idx])
    |=> strain_err && !strain_go) else $error("uninitialised channel measured");

  // ----------------------------------------------------------------
  // initialization sequence and reply
  // ----------------------------------------------------------------
  csh_strain_t reply_data;
  logic [2:0] byte_cnt;
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= CSH_IDLE;
      cmd_r <= '0;
      reply_data <= '0;
      byte_cnt <= 3'h0;
    end else begin
      case (state)
        CSH_IDLE: begin
          if (good && cmd.op == CSH_CMD_INIT) begin
            cmd_r <= cmd;
            state <= CSH_MEAS;
          end
        end
        CSH_MEAS: begin
          if (gauge_meas_done) begin
            reply_data <= gauge_meas;
            byte_cnt <= 3'h0;
            state <= CSH_SEND;
          end
        end
        CSH_SEND: begin
          if (reply_ready) begin
            byte_cnt <= byte_cnt + 3'h1;
            if (byte_cnt == 3'(REPLY_BYTES - 1)) state <= CSH_IDLE;
          end
        end
        default: state <= CSH_IDLE;
      endcase
    end
  end
  assign gauge_meas_req = state == CSH_MEAS;
  assign reply_valid = state == CSH_SEND;
  assign reply_stream = REPLY_STREAM; // RULE10
  // offset bytes first, most significant first
  wire [63:0] reply_word = {reply_data.offset_v, reply_data.initial_v};
  assign reply_byte = reply_word[8'(63 - 8 * byte_cnt) -: 8]; // RULE10

  a_reply_len: assert property (@(posedge clk) disable iff (reset) // RULE10
    reply_valid && reply_ready && byte_cnt == 3'h7 |=> !reply_valid)
    else $error("reply length wrong");

  // ----------------------------------------------------------------
  // digital sample rates
  // ----------------------------------------------------------------
  csh_rate_t [N_DIG-1:0] rate_sel;
  always_ff @(posedge clk) begin
    if (reset) begin
      // each element set by name keeps the enum type intact
      for (int i = 0; i < N_DIG; i++) begin
        rate_sel[i] <= CSH_RATE_DEF; // RULE13
      end
    end else if (good && cmd.op == CSH_CMD_RATE) begin
      rate_sel[didx] <= csh_rate_t'(cmd.arg0[2:0]); // RULE12
    end
  end

  // shared tick generators, one per rate
  localparam int NR = 5;
  localparam int DIVS [NR] = '{DIV_1, DIV_20, DIV_1K, DIV_10K, DIV_100K};
  logic [NR-1:0] tick;
  genvar r;
  generate
    for (r = 0; r < NR; r++) begin : g_tick
      logic [27:0] cnt;
      always_ff @(posedge clk) begin
        if (reset) cnt <= 28'h000_0000;
        else if (cnt == 28'(DIVS[r] - 1)) cnt <= 28'h000_0000;
        else cnt <= cnt + 28'h000_0001;
      end
      assign tick[r] = cnt == 28'(DIVS[r] - 1);
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < N_DIG; c++) begin : g_dig
      logic s1, s2;
      csh_rate_t eff;
      always_ff @(posedge clk) begin
        if (reset) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end else begin
          s1 <= dig_in[c];
          s2 <= s1;
        end
      end
      always_comb begin
        eff = rate_sel[c];
        if (rate_sel[c] == CSH_RATE_DEF) begin
          case (chan_mode[c]) // RULE13
            CSH_MODE_STATUS: eff = CSH_RATE_20;
            CSH_MODE_COUNT: eff = CSH_RATE_1;
            CSH_MODE_CAPTURE: eff = CSH_RATE_1K;
            default: eff = CSH_RATE_100K;
          endcase
        end
      end
      wire ch_tick = eff == CSH_RATE_1 ? tick[0] : eff == CSH_RATE_20 ? tick[1] :
        eff == CSH_RATE_1K ? tick[2] : eff == CSH_RATE_10K ? tick[3] : tick[4];
      wire slow = eff inside {CSH_RATE_20, CSH_RATE_1K}; // RULE14
      csh_debounce u_db (
        .clk(clk),
        .reset(reset),
        .tick(ch_tick),
        .filter_on(slow),
        .din_sync(s2),
        .level(dig_level[c]),
        .change(dig_change[c])
      );
      // flags stamps taken DEBOUNCE_LAG sample periods after the edge
      always_ff @(posedge clk) begin
        if (reset) dig_stamp_late[c] <= 1'b0;
        else dig_stamp_late[c] <= slow; // RULE15
      end
    end
  endgenerate
endmodule

// file: sim/csh_front_model.sv
`timescale 1ns/1ps
// converter front end for gauge readings, plus a slow reader of the reply stream
module csh_front_model #(
  parameter logic [63:0] GAUGE = 64'h3c23_d70a_4120_0000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // gauge measurement
  input wire logic gauge_meas_req,
  output logic gauge_meas_done,
  output csh_pkg::csh_strain_t gauge_meas,
  // reply sink
  input wire logic reply_valid,
  output logic reply_ready
);
  import csh_pkg::*;
  int wait_cnt;
  logic held;
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_cnt <= 0;
      held <= 1'b0;
      gauge_meas_done <= 1'b0;
      gauge_meas <= ~GAUGE;
      reply_ready <= 1'b0;
    end else begin
      // drops ready every other cycle, stalling each byte, so the reply must hold its data
      reply_ready <= reply_valid & ~reply_ready;
      gauge_meas_done <= 1'b0;
      if (gauge_meas_req && !held) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == 5) begin
          gauge_meas_done <= 1'b1;
          gauge_meas <= GAUGE;
          held <= 1'b1;
        end
      end else if (!gauge_meas_req) begin
        // released bus shows the inverse so a stale read is caught
        held <= 1'b0;
        wait_cnt <= 0;
        gauge_meas <= ~GAUGE;
      end
    end
  end
endmodule

// file: sim/channel_setup_command_handler_bench.sv
`timescale 1ns/1ps
module channel_setup_command_handler_bench;
  import csh_pkg::*;
  localparam logic [63:0] GAUGE = 64'h3c23_d70a_4120_0000;
  logic clk = 0, reset = 1, universal_variant = 0, cmd_valid = 0, tc_done = 0, tc_open = 0;
  logic strain_req = 0, gauge_meas_done, reply_valid, reply_ready;
  csh_mode_t [19:0] chan_mode;
  csh_cmd_t cmd = '0;
  logic cmd_ready, cmd_reject, ref_external, oc_check_on, tc_confirm_req, tc_result_valid;
  logic [31:0] ref_temp, strain_factor;
  logic [15:0] tc_value = 0, tc_result, strain_err_code;
  logic [3:0] strain_idx = 0;
  logic strain_go, strain_err, gauge_meas_req;
  csh_strain_t strain_zero, gauge_meas;
  logic [1:0] reply_stream;
  logic [7:0] reply_byte;
  logic [19:0] dig_in = 0, dig_level, dig_change, dig_stamp_late;
  logic [7:0] rx[$];
  int fail_count = 0, checked = 0;
  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  csh_cmd_handler u_dut (.clk(clk), .reset(reset), .universal_variant(universal_variant),
    .chan_mode(chan_mode), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .cmd_reject(cmd_reject), .ref_temp(ref_temp), .ref_external(ref_external),
    .oc_check_on(oc_check_on), .tc_done(tc_done), .tc_value(tc_value), .tc_open(tc_open),
    .tc_confirm_req(tc_confirm_req), .tc_result_valid(tc_result_valid), .tc_result(tc_result),
    .strain_req(strain_req), .strain_idx(strain_idx), .strain_go(strain_go),
    .strain_err(strain_err), .strain_err_code(strain_err_code), .strain_factor(strain_factor),
    .strain_zero(strain_zero), .gauge_meas_req(gauge_meas_req),
    .gauge_meas_done(gauge_meas_done), .gauge_meas(gauge_meas), .reply_valid(reply_valid),
    .reply_stream(reply_stream), .reply_byte(reply_byte), .reply_ready(reply_ready),
    .dig_in(dig_in), .dig_level(dig_level), .dig_change(dig_change),
    .dig_stamp_late(dig_stamp_late));
  csh_front_model #(.GAUGE(GAUGE)) u_front (.clk(clk), .reset(reset),
    .gauge_meas_req(gauge_meas_req), .gauge_meas_done(gauge_meas_done),
    .gauge_meas(gauge_meas), .reply_valid(reply_valid), .reply_ready(reply_ready));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reply_valid === 1'b1 && reply_ready === 1'b1) begin
      rx.push_back(reply_byte);
      if (reply_stream !== REPLY_STREAM) begin
        fail_count++;
        $display("BAD %0t reply stream", $time);
      end
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic send(input csh_op_t op, input int ch, input logic [31:0] a0,
                      input logic [31:0] a1, input logic rej);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, ch[4:0], a0, a1};
    #1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 100, 1, "cmd not taken");
    if (n >= 100) begin
      finish_test();
    end else begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      chk(cmd_reject, rej, "reject flag");
    end
  endtask
  task automatic tc(input logic [15:0] v, input logic open);
    @(posedge clk);
    tc_done <= 1'b1;
    tc_value <= v;
    tc_open <= open;
    @(posedge clk);
    tc_done <= 1'b0;
    #1;
  endtask
  task automatic strain(input int idx, input logic go);
    @(posedge clk);
    strain_req <= 1'b1;
    strain_idx <= idx[3:0];
    @(posedge clk);
    strain_req <= 1'b0;
    #1;
    chk({strain_go, strain_err}, {go, ~go}, "strain answer");
  endtask
  task automatic dig(input int i, input int bound, input logic fast);
    int n;
    n = 0;
    @(posedge clk);
    dig_in[i] <= ~dig_in[i];
    #1;
    while (dig_change[i] !== 1'b1 && n < bound) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < bound, fast, "level change timing");
    if (fast && n >= bound)
      finish_test();
    else if (fast)
      chk(dig_level[i], dig_in[i], "accepted level");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 20; i++)
      chan_mode[i] = CSH_MODE_FREQ;
    chan_mode[0] = CSH_MODE_STATUS;
    chan_mode[4] = CSH_MODE_CAPTURE;
    chan_mode[6] = CSH_MODE_COUNT;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({cmd_ready, ref_external, oc_check_on}, 3'b100, "reset state");
    send(CSH_CMD_REF_TEMP, 0, 32'h41c8_0000, 0, 0);
    chk({ref_external, ref_temp, reply_valid}, {1'b1, 32'h41c8_0000, 1'b0}, "ref");
    tc(16'h1234, 1);
    chk({tc_result_valid, tc_confirm_req, tc_result}, {2'b10, 16'h1234}, "tc off");
    send(CSH_CMD_OC_CHECK, 0, 2, 0, 1);
    send(CSH_CMD_OC_CHECK, 0, 1, 0, 0);
    chk(oc_check_on, 1, "oc on");
    tc(16'h0042, 0);
    chk({tc_confirm_req, tc_result_valid}, 2'b10, "confirm asked");
    tc(16'h0000, 1);
    chk({tc_result_valid, tc_result}, {1'b1, ERR_OPEN_CIRCUIT}, "open circuit");
    tc(16'h0077, 0);
    tc(16'h0000, 0);
    chk({tc_result_valid, tc_result}, {1'b1, 16'h0077}, "confirmed");
    send(CSH_CMD_OC_CHECK, 0, 0, 0, 0);
    chk(oc_check_on, 0, "oc off");
    strain(0, 0);
    chk(strain_err_code, ERR_NOT_INIT, "not init code");
    send(CSH_CMD_GAUGE, 11, 32'h4000_0000, 0, 1);
    send(CSH_CMD_GAUGE, 0, 32'h4000_0000, 0, 1);
    send(CSH_CMD_GAUGE, 1, 32'h4000_0000, 0, 0);
    strain(0, 0);
    send(CSH_CMD_OFFSET, 1, 32'h3f00_0000, 32'h4110_0000, 0);
    strain(0, 1);
    chk({strain_factor, strain_zero}, {32'h4000_0000, 64'h3f00_0000_4110_0000}, "p1");
    send(CSH_CMD_GAUGE, 10, 32'h4040_0000, 0, 0);
    send(CSH_CMD_INIT, 2, 0, 0, 0);
    chk({cmd_ready, gauge_meas_req}, 2'b01, "init busy");
    for (int n = 0; n < 200 && rx.size() < 8; n++)
      @(posedge clk);
    chk(rx.size(), 8, "reply length");
    if (rx.size() != 8)
      finish_test();
    for (int k = 0; k < 8 && k < rx.size(); k++)
      chk(rx[k], GAUGE[63 - 8 * k -: 8], "reply byte");
    send(CSH_CMD_GAUGE, 2, 32'h4000_0000, 0, 0);
    strain(1, 1);
    chk(strain_zero, GAUGE, "init stored");
    strain(9, 0);
    send(CSH_CMD_RATE, 21, 4, 0, 1);
    send(CSH_CMD_RATE, 0, 4, 0, 1);
    send(CSH_CMD_RATE, 5, 5, 0, 1);
    // codes 1 and 2 are the debounced rates, 3 and 4 the fast ones
    for (int c = 1; c <= 4; c++) begin
      send(CSH_CMD_RATE, 5, c, 0, 0);
      @(posedge clk);
      #1;
      chk(dig_stamp_late[4], c <= 2, "rate code slow");
    end
    send(CSH_CMD_RATE, 5, 0, 0, 0);
    send(CSH_CMD_RATE, 2, 4, 0, 0);
    send(CSH_CMD_RATE, 3, 3, 0, 0);
    @(posedge clk);
    universal_variant <= 1'b1;
    send(CSH_CMD_RATE, 18, 4, 0, 1);
    send(CSH_CMD_RATE, 20, 4, 0, 0);
    @(posedge clk);
    universal_variant <= 1'b0;
    dig(0, 2510, 0);
    dig(4, 2510, 0);
    dig(5, 2510, 1);
    dig(1, 2510, 1);
    dig(2, 25010, 1);
    dig(19, 2510, 1);
    // only the status (20Hz) and capture (1kHz) defaults remain debounced
    chk(dig_stamp_late, 20'h0_0011, "late stamp flags");
    finish_test();
  end
endmodule
